/* File: hw/ifd_top.sv */
// Purpose: Fetch buffer, decoder selection and micro-op group output.
// Assumes: Cache delivers an aligned 32-byte block with predecode; ready/valid.
// Notes:   Byte 0 bits 7:5 give class, bit 4 asks a memory op; ROM steps are stubbed.
`timescale 1ns/10ps
module ifd_top
    import ifd_pkg::*;
(
    // Clock and reset
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_rst_n,
    // Fetch side
    input  wire logic                         i_fetch_valid,
    input  wire logic                         i_fetch_from_btc,
    input  wire logic [BLK_BYTES*8-1:0]       i_fetch_blk,
    input  wire logic [BLK_BYTES*PD_W-1:0]    i_fetch_pd,
    input  wire logic [4:0]                   i_fetch_off,
    output logic                              o_fetch_ready,
    output logic                              o_fetch_req,
    // Control transfers
    input  wire logic                         i_redirect,
    input  wire logic                         i_branch_taken,
    input  wire logic                         i_branch_resolved,
    output logic [2:0]                        o_branch_cnt,
    // Scheduler side
    output logic                              o_grp_valid,
    output logic [GROUP_OPS*UOP_W-1:0]        o_grp_ops,
    input  wire logic                         i_grp_ready,
    input  wire logic                         i_grp_retire,
    output logic [2:0]                        o_sched_cnt
);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [UOP_W-1:0] mk_uop(input logic [3:0] op, input logic [7:0] b);
        mk_uop = {op, 20'h0_0000, b};
    endfunction

    // ------------------------------------------------------------
    // Instruction buffer
    // ------------------------------------------------------------
    logic [7:0]       buf_byte_reg [BUF_BYTES];
    logic [PD_W-1:0]  buf_pd_reg   [BUF_BYTES];
    logic [4:0]       buf_cnt_reg;
    logic [4:0]       consume;
    logic             take_fetch;
    logic             grp_push;
    logic [7:0]       fb           [BUF_BYTES];
    logic [PD_W-1:0]  fp           [BUF_BYTES];

    // Any 16 bytes of the 32-byte block, line crossing included, in one cycle
    always_comb begin
        for (int i = 0; i < BUF_BYTES; i++) begin
            fb[i] = i_fetch_blk[8*(5'(i_fetch_off + 5'(i)))+:8]; // RL4 RL5
            fp[i] = i_fetch_pd[PD_W*(5'(i_fetch_off + 5'(i)))+:PD_W]; // RL21
        end
    end

    // Refill only in whole words; fresh fetch only after redirect or when the buffer is empty
    assign take_fetch    = i_fetch_valid && o_fetch_ready; // RL1
    assign o_fetch_ready = (buf_cnt_reg == 5'd0) || i_redirect; // RL6 RL7

    // Buffer contents: shift out consumed bytes, or replace all sixteen on a fetch
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            buf_cnt_reg <= 5'd0;
            for (int i = 0; i < BUF_BYTES; i++) begin
                buf_byte_reg[i] <= 8'h00;
                buf_pd_reg[i]   <= '0;
            end
        end else if (i_redirect) begin
            buf_cnt_reg <= 5'd0; // RL7
        end else if (take_fetch) begin
            buf_cnt_reg <= 5'd16; // RL1 RL2
            for (int i = 0; i < BUF_BYTES; i++) begin
                buf_byte_reg[i] <= fb[i];
                buf_pd_reg[i]   <= fp[i];
            end
        end else if (grp_push) begin
            // Word-granular consume: round up so the next start stays word aligned
            buf_cnt_reg <= buf_cnt_reg - consume; // RL6
            for (int i = 0; i < BUF_BYTES; i++) begin
                if (5'(i) + consume < 5'd16) begin
                    buf_byte_reg[i] <= buf_byte_reg[4'(5'(i) + consume)];
                    buf_pd_reg[i]   <= buf_pd_reg[4'(5'(i) + consume)];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Boundary finding and decoder selection
    // ------------------------------------------------------------
    logic [4:0]      len0, len1;
    ifd_cls_t        cls0, cls1;
    logic            mem0, mem1;
    logic            short0_ok, short1_ok, have0, have1;
    ifd_sel_t        sel;
    logic [UOP_W-1:0] ops [GROUP_OPS];
    logic [ROM_AW-1:0] rom_addr;

    // Predecode distance gives each instruction length
    always_comb begin
        len0 = 5'(buf_pd_reg[0]); // RL8 RL21
        if (len0 == 5'd0 || len0 > 5'(MAX_INSTR))
            len0 = 5'd1; // RL22
        len1 = (len0 < 5'd16) ? 5'(buf_pd_reg[4'(len0)]) : 5'd0;
        cls0 = ifd_cls_t'(buf_byte_reg[0][7:5]);
        mem0 = buf_byte_reg[0][4];
        cls1 = (len0 < 5'd16) ? ifd_cls_t'(buf_byte_reg[4'(len0)][7:5]) : CLS_CMPLX;
        mem1 = (len0 < 5'd16) ? buf_byte_reg[4'(len0)][4] : 1'b0;
        have0 = (buf_cnt_reg != 5'd0) && (len0 <= buf_cnt_reg); // RL24
        have1 = (len1 != 5'd0) && (len0 + len1 <= buf_cnt_reg);
        short0_ok = (len0 <= 5'(SHORT_MAX)) && (cls0 inside {CLS_NOP, CLS_SIMPLE, CLS_FLOAT, CLS_MEDIA}); // RL11 RL20
        // Escape only on first short decoder
        short1_ok = have1 && (len1 <= 5'(SHORT_MAX)) && (cls1 inside {CLS_NOP, CLS_SIMPLE, CLS_MEDIA}); // RL18
        // Exactly one decoder type drives the group
        if (!have0)
            sel = SEL_NONE; // RL24
        else if (short0_ok)
            sel = SEL_SHORT;
        else if ((cls0 == CLS_SIMPLE && len0 <= 5'(LONG_MAX)) || (cls0 == CLS_UNCOMM && len0 <= 5'(SHORT_MAX)))
            sel = SEL_LONG; // RL12
        else
            sel = SEL_VECTOR; // RL14 RL15
    end

    // Micro-op group forming, four slots padded with no-ops
    always_comb begin
        for (int k = 0; k < GROUP_OPS; k++)
            ops[k] = UOP_NOP; // RL16
        rom_addr = {buf_byte_reg[0], 2'b00};
        consume  = 5'd0;
        case (sel)
            SEL_SHORT: begin
                // Zero ops for a no-op, one op plus optional memory op otherwise
                if (cls0 != CLS_NOP) begin
                    ops[0] = mk_uop(cls0 == CLS_FLOAT ? OP_FLT : (cls0 == CLS_MEDIA ? OP_MED : OP_ALU),
                                    buf_byte_reg[0]); // RL9 RL19 RL20
                    if (mem0)
                        ops[1] = mk_uop(OP_MEM, buf_byte_reg[0]);
                end
                consume = len0;
                if (short1_ok) begin
                    if (cls1 != CLS_NOP) begin
                        ops[2] = mk_uop(cls1 == CLS_MEDIA ? OP_MED : OP_ALU, buf_byte_reg[4'(len0)]); // RL10
                        if (mem1)
                            ops[3] = mk_uop(OP_MEM, buf_byte_reg[4'(len0)]);
                    end
                    consume = len0 + len1;
                end
            end
            SEL_LONG: begin
                // One instruction, up to four ops
                for (int k = 0; k < LONG_MAX_OPS; k++)
                    if (k <= int'(buf_byte_reg[0][1:0]))
                        ops[k] = mk_uop(OP_ALU, buf_byte_reg[k]); // RL13
                consume = len0;
            end
            SEL_VECTOR: begin
                ops[0]  = mk_uop(OP_VEC, buf_byte_reg[0]); // RL14
                ops[1]  = {OP_ROM, 18'h0_0000, rom_addr};
                consume = len0;
            end
            default: begin
                consume = 5'd0;
            end
        endcase
        // Keep refill word aligned
        consume = (consume + 5'd1) & 5'h1e; // RL6
        if (consume > buf_cnt_reg)
            consume = buf_cnt_reg;
    end

    // ------------------------------------------------------------
    // Two-entry output buffer and scheduler occupancy
    // ------------------------------------------------------------
    logic [GROUP_OPS*UOP_W-1:0] ob_data_reg [2];
    logic [1:0]                 ob_cnt_reg;
    logic                       ob_rd_reg, ob_wr_reg;
    logic                       ob_pop;
    logic                       sched_room;

    assign sched_room = o_sched_cnt < 3'(SCHED_GROUPS);
    assign ob_pop     = (ob_cnt_reg != 2'd0) && i_grp_ready && sched_room; // RL17
    // Stall decode when buffer full; nothing leaves the instruction buffer
    assign grp_push   = (sel != SEL_NONE) && !i_redirect && (ob_cnt_reg != 2'd2 || ob_pop); // RL23

    // Buffer pointers and storage
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ob_cnt_reg <= 2'd0;
            ob_rd_reg  <= 1'b0;
            ob_wr_reg  <= 1'b0;
            ob_data_reg[0] <= '0;
            ob_data_reg[1] <= '0;
        end else begin
            if (grp_push) begin
                ob_data_reg[ob_wr_reg] <= {ops[3], ops[2], ops[1], ops[0]};
                ob_wr_reg <= ~ob_wr_reg;
            end
            if (ob_pop)
                ob_rd_reg <= ~ob_rd_reg;
            ob_cnt_reg <= ob_cnt_reg + 2'(grp_push) - 2'(ob_pop);
        end
    end

    // Registered group output to scheduler
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_grp_valid <= 1'b0;
            o_grp_ops   <= '0;
        end else begin
            o_grp_valid <= ob_pop;
            o_grp_ops   <= ob_pop ? ob_data_reg[ob_rd_reg] : o_grp_ops;
        end
    end

    // Scheduler occupancy in groups, retire frees one
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_sched_cnt <= 3'd0;
        else
            o_sched_cnt <= o_sched_cnt + 3'(ob_pop) - 3'(i_grp_retire && o_sched_cnt != 3'd0); // RL17
    end

    // ------------------------------------------------------------
    // Branch tracking and fetch request
    // ------------------------------------------------------------
    // Fetch holds off once seven taken branches are outstanding
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_branch_cnt <= 3'd0;
            o_fetch_req  <= 1'b0;
        end else begin
            o_branch_cnt <= o_branch_cnt
                          + 3'(i_branch_taken && o_branch_cnt != 3'(MAX_BRANCHES))
                          - 3'(i_branch_resolved && o_branch_cnt != 3'd0); // RL3
            o_fetch_req  <= (buf_cnt_reg <= 5'd2) && (o_branch_cnt < 3'(MAX_BRANCHES)); // RL3
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sched_limit:   assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_sched_cnt <= 3'd6) else $error("scheduler over six groups"); // RL17
    a_branch_limit:  assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_branch_cnt <= 3'd7) else $error("more than seven branches"); // RL3
    a_flush_empty:   assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_redirect |=> buf_cnt_reg == 5'd0) else $error("flush left bytes"); // RL7
    a_fill_sixteen:  assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        take_fetch && !i_redirect |=> buf_cnt_reg == 5'd16) else $error("fill not 16 bytes"); // RL1
    a_word_consume:  assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        grp_push && consume != buf_cnt_reg |-> consume[0] == 1'b0) else $error("odd consume"); // RL6
    a_no_partial:    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        grp_push |-> len0 <= buf_cnt_reg) else $error("partial instruction"); // RL24
    a_stall_hold:    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ob_cnt_reg == 2'd2 && !ob_pop && !i_redirect && !take_fetch |=> $stable(buf_cnt_reg))
        else $error("buffer moved while stalled"); // RL23
    a_pop_follow:    assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ob_pop |=> o_grp_valid) else $error("group not delivered"); // RL16
    a_long_len:      assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        sel == SEL_LONG |-> len0 <= 5'd11) else $error("long over eleven"); // RL12
    a_esc_first:     assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        short1_ok |-> cls1 != CLS_FLOAT) else $error("escape in second decoder"); // RL18
    c_dual_short:    cover property (@(posedge i_ref_clk) sel == SEL_SHORT && short1_ok && grp_push);
    c_vector:        cover property (@(posedge i_ref_clk) sel == SEL_VECTOR && grp_push);
    c_full_sched:    cover property (@(posedge i_ref_clk) o_sched_cnt == 3'd6);

endmodule

/* File: hw/ifd_pkg.sv */
// Purpose: Constants for the instruction fetch and decode front end.
// Assumes: One processor clock; caches and scheduler are plain logic outside.
// Notes:   Overview follows; tags mark where each point is carried out.
//
// Overview of operation
// [RL1] Fetch brings at most sixteen bytes per clock from cache or target cache.
// [RL2] Fetched bytes land in a sixteen-byte buffer seen by all decoders.
// [RL3] One fetch stream; at most seven taken branches outstanding.
// [RL4] Any sixteen contiguous bytes inside one aligned 32-byte block can be fetched.
// [RL5] Fetch across a cache line boundary costs no extra cycle.
// [RL6] Buffer refilled as bytes are consumed, in aligned two-byte words; here a refill waits for an empty buffer and loads sixteen bytes.
// [RL7] A control transfer flushes the buffer and reloads sixteen target bytes.
// [RL8] Decode takes bytes plus predecode, finds boundaries, emits fixed micro-ops.
// [RL9] Instruction yields zero, one or several micro-ops.
// [RL10] Two short decoders, one long decoder, one vector decoder.
// [RL11] Short decoders take up to seven bytes, zero to two ops each.
// [RL12] Long decoder takes common up to eleven bytes, uncommon up to seven.
// [RL13] Long decoder does one instruction per clock, at most four ops.
// [RL14] Everything else goes to vector decoder with ROM address sequencing; here one ROM op carries the start address and no further steps follow.
// [RL15] All decoders see the buffer; exactly one type produces output.
// [RL16] Output is always a group of four, unused slots padded with no-ops.
// [RL17] Scheduler holds at most six groups, twenty-four micro-ops.
// [RL18] Float escape only in first short decoder; second may take non-escape.
// [RL19] Short float decode gives one float op plus optional load or store.
// [RL20] Multimedia ops except clears and preload are short, op plus optional memory.
// [RL21] Each byte carries five predecode bits giving distance to next start.
// [RL22] Instructions from one to fifteen bytes are accepted.
// [RL23] Scheduler full: decoders stall and keep the buffer contents.
// [RL24] Incomplete next instruction in buffer: no group that clock.
package ifd_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int BUF_BYTES      = 16;
    localparam int BLK_BYTES      = 32;
    localparam int WORD_BYTES     = 2;
    localparam int PD_W           = 5;
    localparam int MAX_INSTR      = 15;
    localparam int SHORT_MAX      = 7;
    localparam int LONG_MAX       = 11;
    localparam int LONG_MAX_OPS   = 4;
    localparam int GROUP_OPS      = 4;
    localparam int SCHED_GROUPS   = 6;
    localparam int MAX_BRANCHES   = 7;
    localparam int UOP_W          = 32;
    localparam int ROM_AW         = 10;

    // ------------------------------------------------------------
    // Instruction class, carried in the first byte's top bits
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_NOP    = 3'h0,
        CLS_SIMPLE = 3'h1,
        CLS_FLOAT  = 3'h2,
        CLS_MEDIA  = 3'h3,
        CLS_UNCOMM = 3'h4,
        CLS_CMPLX  = 3'h5,
        CLS_MCLR   = 3'h6,
        CLS_PRELD  = 3'h7
    } ifd_cls_t;

    // Decoder selected per clock
    typedef enum logic [1:0] {
        SEL_NONE   = 2'b00,
        SEL_SHORT  = 2'b01,
        SEL_LONG   = 2'b10,
        SEL_VECTOR = 2'b11
    } ifd_sel_t;

    localparam logic [UOP_W-1:0] UOP_NOP   = 32'h0000_0000;
    localparam logic [3:0]       OP_ALU    = 4'h1;
    localparam logic [3:0]       OP_FLT    = 4'h2;
    localparam logic [3:0]       OP_MED    = 4'h3;
    localparam logic [3:0]       OP_MEM    = 4'h4;
    localparam logic [3:0]       OP_VEC    = 4'h5;
    localparam logic [3:0]       OP_ROM    = 4'h6;
    localparam logic [ROM_AW-1:0] ROM_LEN_MASK = 10'h003;

endpackage

/* File: bench/ifd_sched_model.sv */
// Purpose: Scheduler-side partner that takes micro-op groups and retires them.
// Assumes: A group enters the scheduler on the cycle its valid pulse is high.
// Notes:   Retires one group every other cycle while the bench allows it.
`timescale 1ns/10ps
module ifd_sched_model
    import ifd_pkg::*;
(
    // Clock and reset
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst_n,
    // Group stream from the decoder
    input  wire logic                       i_grp_valid,
    input  wire logic [GROUP_OPS*UOP_W-1:0] i_grp_ops,
    // Bench controls
    input  wire logic                       i_ready_en,
    input  wire logic                       i_retire_en,
    // Handshake back to the decoder
    output logic                            o_grp_ready,
    output logic                            o_grp_retire
);
    int occ_reg;
    int counts[$];

    // Ready follows the bench so that stalls can be commanded
    assign o_grp_ready = i_ready_en;

    // Retire only every other cycle, so retire stays a one-cycle pulse
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            occ_reg      <= 0;
            o_grp_retire <= 1'b0;
        end else begin
            o_grp_retire <= i_retire_en && !o_grp_retire && (occ_reg > 0);
            occ_reg      <= occ_reg + int'(i_grp_valid) - int'(o_grp_retire);
        end
    end

    // Count the non-empty slots of every group taken
    always @(posedge i_ref_clk) begin
        int nz;
        nz = 0;
        if (i_rst_n && i_grp_valid === 1'b1) begin
            for (int k = 0; k < GROUP_OPS; k++) nz += int'(i_grp_ops[k*UOP_W +: UOP_W] != UOP_NOP);
            counts.push_back(nz);
        end
    end
endmodule

/* File: bench/tb_instruction_fetch_decode.sv */
// Purpose: Self-checking bench for the fetch and decode front end.
// Assumes: Byte 0 bits 7:5 class, bit 4 memory op, bits 1:0 long op count less one.
// Notes:   Groups are judged by the count of non-empty slots the partner saw.
`timescale 1ns/10ps
module tb_instruction_fetch_decode
    import ifd_pkg::*;
;
    logic         i_ref_clk, i_rst_n, i_fetch_valid, i_fetch_from_btc;
    logic [255:0] i_fetch_blk, blk_v;
    logic [159:0] i_fetch_pd, pd_v;
    logic [4:0]   i_fetch_off;
    logic         i_redirect, i_branch_taken, i_branch_resolved;
    logic         i_grp_ready, i_grp_retire, o_fetch_ready, o_fetch_req, o_grp_valid;
    logic [127:0] o_grp_ops;
    logic [2:0]   o_branch_cnt, o_sched_cnt;
    logic         ready_en, retire_en;
    int           n_mismatch, total_checks, cyc, lat;

    ifd_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_fetch_valid(i_fetch_valid),
        .i_fetch_from_btc(i_fetch_from_btc), .i_fetch_blk(i_fetch_blk), .i_fetch_pd(i_fetch_pd),
        .i_fetch_off(i_fetch_off), .o_fetch_ready(o_fetch_ready), .o_fetch_req(o_fetch_req),
        .i_redirect(i_redirect), .i_branch_taken(i_branch_taken), .i_branch_resolved(i_branch_resolved),
        .o_branch_cnt(o_branch_cnt), .o_grp_valid(o_grp_valid), .o_grp_ops(o_grp_ops),
        .i_grp_ready(i_grp_ready), .i_grp_retire(i_grp_retire), .o_sched_cnt(o_sched_cnt));
    ifd_sched_model u_sched (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_grp_valid(o_grp_valid),
        .i_grp_ops(o_grp_ops), .i_ready_en(ready_en), .i_retire_en(retire_en),
        .o_grp_ready(i_grp_ready), .o_grp_retire(i_grp_retire));

    // 50 MHz clock and a hang guard well above the expected run
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Block building; every block is filled whole so no stray no-op groups appear
    task automatic put(input int pos, input logic [7:0] b0, input int len);
        blk_v[pos*8 +: 8] = b0;
        pd_v[pos*5 +: 5]  = len[4:0];
    endtask
    task automatic pairs(input int pos, input int n);
        for (int k = 0; k < n; k++) put((pos + 2*k) % 32, 8'h20, 2);
    endtask

    // Fetch holds valid until an edge with ready high, then times the first group
    task automatic fetch(input logic [4:0] off);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_fetch_valid <= 1'b1;
        i_fetch_off   <= off;
        i_fetch_blk   <= blk_v;
        i_fetch_pd    <= pd_v;
        @(negedge i_ref_clk);
        while (o_fetch_ready !== 1'b1 && n < 200) begin
            @(negedge i_ref_clk);
            n++;
        end
        @(posedge i_ref_clk);
        i_fetch_valid <= 1'b0;
        blk_v = '0;
        pd_v  = {32{5'h01}};
        lat   = 0;
        for (int k = 0; k < 50; k++) begin
            @(negedge i_ref_clk);
            if (o_grp_valid === 1'b1) break;
            lat++;
        end
    endtask

    task automatic expect_groups(input int n, input int e[8]);
        int w;
        w = 0;
        while (u_sched.counts.size() < n && w < 300) begin
            @(negedge i_ref_clk);
            w++;
        end
        repeat (10) @(negedge i_ref_clk);
        chk(u_sched.counts.size(), n);
        for (int k = 0; k < n && k < u_sched.counts.size(); k++) chk(u_sched.counts[k], e[k]);
        u_sched.counts.delete();
    endtask

    // Scenarios
    task automatic t_wrap();
        i_fetch_from_btc <= 1'b1;
        pairs(24, 8);
        fetch(5'h18);
        chk(lat, 2);
        expect_groups(4, '{2, 2, 2, 2, 0, 0, 0, 0});
        i_fetch_from_btc <= 1'b0;
        pairs(0, 8);
        fetch(5'h00);
        chk(lat, 2);
        expect_groups(4, '{2, 2, 2, 2, 0, 0, 0, 0});
    endtask

    task automatic t_long_nop();
        put(0, 8'h23, 8);
        put(8, 8'h22, 8);
        fetch(5'h00);
        expect_groups(2, '{4, 3, 0, 0, 0, 0, 0, 0});
        put(0, 8'h00, 2);
        pairs(2, 7);
        fetch(5'h00);
        expect_groups(4, '{1, 2, 2, 2, 0, 0, 0, 0});
    endtask

    task automatic t_float_media();
        put(0, 8'h50, 2);
        put(2, 8'h50, 2);
        pairs(4, 6);
        fetch(5'h00);
        expect_groups(5, '{2, 3, 2, 2, 1, 0, 0, 0});
        put(0, 8'h70, 2);
        put(2, 8'h70, 2);
        pairs(4, 6);
        fetch(5'h00);
        expect_groups(4, '{4, 2, 2, 2, 0, 0, 0, 0});
    endtask

    task automatic t_vector();
        put(0, 8'hA0, 4);
        put(4, 8'hC0, 4);
        put(8, 8'hE0, 4);
        put(12, 8'h81, 4);
        fetch(5'h00);
        expect_groups(4, '{2, 2, 2, 2, 0, 0, 0, 0});
    endtask

    // Scheduler refuses, then fills to six groups, then drains
    task automatic t_stall();
        @(posedge i_ref_clk);
        ready_en <= 1'b0;
        pairs(0, 8);
        fetch(5'h00);
        chk(u_sched.counts.size(), 0);
        @(posedge i_ref_clk);
        retire_en <= 1'b0;
        ready_en  <= 1'b1;
        pairs(0, 8);
        fetch(5'h00);
        repeat (40) @(negedge i_ref_clk);
        chk(o_sched_cnt, 6);
        chk(u_sched.counts.size(), 6);
        @(posedge i_ref_clk);
        retire_en <= 1'b1;
        expect_groups(8, '{2, 2, 2, 2, 2, 2, 2, 2});
    endtask

    task automatic t_redirect();
        @(posedge i_ref_clk);
        ready_en <= 1'b0;
        pairs(0, 8);
        fetch(5'h00);
        @(posedge i_ref_clk);
        i_redirect <= 1'b1;
        @(negedge i_ref_clk);
        chk(o_fetch_ready, 1);
        @(posedge i_ref_clk);
        i_redirect <= 1'b0;
        @(negedge i_ref_clk);
        chk(o_fetch_ready, 1);
        @(posedge i_ref_clk);
        ready_en <= 1'b1;
        repeat (30) @(negedge i_ref_clk);
        u_sched.counts.delete();
        put(0, 8'h23, 8);
        put(8, 8'h22, 8);
        fetch(5'h00);
        expect_groups(2, '{4, 3, 0, 0, 0, 0, 0, 0});
    endtask

    task automatic t_branch();
        @(posedge i_ref_clk);
        i_branch_taken <= 1'b1;
        repeat (9) @(posedge i_ref_clk);
        i_branch_taken <= 1'b0;
        repeat (2) @(negedge i_ref_clk);
        chk({o_branch_cnt, o_fetch_req}, 32'h0000_000E);
        @(posedge i_ref_clk);
        i_branch_resolved <= 1'b1;
        @(posedge i_ref_clk);
        i_branch_resolved <= 1'b0;
        repeat (2) @(negedge i_ref_clk);
        chk({o_branch_cnt, o_fetch_req}, 32'h0000_000D);
    endtask

    initial begin
        {i_rst_n, i_fetch_valid, i_fetch_from_btc, i_redirect} = '0;
        {i_branch_taken, i_branch_resolved, i_fetch_off} = '0;
        {i_fetch_blk, i_fetch_pd, cyc, n_mismatch, total_checks} = '0;
        blk_v     = '0;
        pd_v      = {32{5'h01}};
        ready_en  = 1'b1;
        retire_en = 1'b1;
        repeat (6) @(posedge i_ref_clk);
        chk({o_grp_valid, o_fetch_req, o_branch_cnt, o_sched_cnt}, 0);
        i_rst_n <= 1'b1;
        t_wrap();
        t_long_nop();
        t_float_media();
        t_vector();
        t_stall();
        t_redirect();
        t_branch();
        tally_and_finish();
    end
endmodule
